// >>> rtl/adcf_pkg.sv
// constants, types and register map of the converter status-flag block
// Notes on behaviour
// - only last-result read clears data ready
// - stored result updates channel, last, data ready
// - channel or last-result read clears done flag
// - stored result with data ready sets overrun
// - status read clears global overrun, set wins
// - stored channel result with done active sets overrun
// - status read clears channel overruns
// - disabled channel never raises its done flag
// - channel read clears only that done flag
// - disabling other channel keeps data ready rise
// - result read never hides global overrun set
// - unstored conversion never sets data ready
// - sleep starts only at a conversion end
package adcf_pkg;
   localparam int NCH = 4;               // converter channels
   localparam int RES_W = 10;            // result width
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;    // write: start bit
   localparam logic [7:0] OFS_MODE = 8'h04;    // sleep selection
   localparam logic [7:0] OFS_CHEN = 8'h10;    // write ones to enable
   localparam logic [7:0] OFS_CHDIS = 8'h14;   // write ones to disable
   localparam logic [7:0] OFS_CHSTAT = 8'h18;  // enabled channels
   localparam logic [7:0] OFS_STATUS = 8'h1C;  // flags, read clears overruns
   localparam logic [7:0] OFS_LAST = 8'h20;    // last_result_register
   localparam logic [7:0] OFS_EVENT = 8'h28;   // sticky events, write one clears
   localparam logic [7:0] OFS_MASK = 8'h2C;    // interrupt mask
   localparam logic [7:0] OFS_RES0 = 8'h30;    // channel_result_reg_n, 4 words
   // field positions
   localparam int CTRL_START = 0;
   localparam int MODE_SLEEP = 0;
   localparam int ST_DONE = 0;           // done flags [3:0]
   localparam int ST_OVR = 8;            // channel overruns [11:8]
   localparam int ST_DATA_READY_FLAG = 16;
   localparam int ST_GOVR = 17;
   localparam int ST_BUSY = 18;
   localparam int ST_SLEEP = 19;
   localparam int LAST_CH = 12;          // channel tag [13:12]
   localparam int EV_W = 4;
   localparam int EV_STORE = 0;
   localparam int EV_GOVR = 1;
   localparam int EV_OVR = 2;
   localparam int EV_SLEEP = 3;
   // reset values
   localparam logic [NCH-1:0] CHEN_RST = 4'h0;
   localparam logic [EV_W-1:0] MASK_RST = 4'h0;
   // conversion timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int CONV_TIME_NS = 2000;   // one conversion
   localparam int CONV_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;
   typedef enum logic [0:0] {
      SEQ_IDLE = 1'b0,
      SEQ_CONV = 1'b1
   } adcf_seq_t;
   // captured address phase of a bus transfer
   typedef struct packed {
      logic vld;
      logic wr;
      logic [7:0] addr;
   } adcf_aphase_t;
endpackage : adcf_pkg

// >>> rtl/adcf_flag.sv
// sticky flag with a set that wins over a clear
`timescale 1ns/1ps
module adcf_flag (
   input wire logic clk,     // block clock
   input wire logic rst,     // synchronous reset, high
   input wire logic setEv,   // event that raises the flag
   input wire logic clrEv,   // read or write that clears it
   output logic flag         // flag state
);
   logic flag_q;
   logic flag_d;

   // set beats clear, so an event in the clearing cycle survives
   always_comb begin
      flag_d = setEv | (flag_q & ~clrEv);
   end

   // flag register
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;
endmodule : adcf_flag

// >>> rtl/adcf_status.sv
// converter status flags, result registers, sequencer and bus slave
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module adcf_status (
   input wire logic ref_clk,              // 40 MHz clock
   input wire logic srst,                 // synchronous reset, high
   input wire logic hsel,                 // slave select
   input wire logic [31:0] haddr,         // byte address
   input wire logic [1:0] htrans,         // transfer type
   input wire logic hwrite,               // write when high
   input wire logic [2:0] hsize,          // word writes only, reads any size
   input wire logic hready,               // bus ready
   input wire logic [31:0] hwdata,        // write data
   output logic [31:0] hrdata,            // read data
   output logic hreadyout,                // always ready
   output logic hresp,                    // always okay
   input wire logic [9:0] anaResult,      // digital word from the analog core
   output logic [1:0] anaChannel,         // channel being converted
   output logic anaSleep,                 // analog core powered down
   output logic irq                       // level interrupt
);
   localparam int N = adcf_pkg::NCH;

   // bus state
   adcf_pkg::adcf_aphase_t aph_q;         // pending data phase
   logic [31:0] hrdata_q;                 // registered read data
   logic rdEn;                            // read taken this cycle
   logic [7:0] rdAddr;                    // read byte address
   logic wrEn;                            // write data phase
   logic [31:0] rdMux;                    // read value

   // configuration and results
   logic sleepSel_q;                      // sleep selection
   logic [N-1:0] chanEn_q;                // enabled channels
   logic [adcf_pkg::EV_W-1:0] mask_q;     // interrupt mask
   logic [adcf_pkg::EV_W-1:0] evt_q;      // sticky events
   logic [adcf_pkg::EV_W-1:0] evtSet;     // event sources
   logic [9:0] chanRes_q [N];             // per-channel results
   logic [9:0] lastRes_q;                 // last stored result
   logic [1:0] lastCh_q;                  // its channel

   // sequencer
   adcf_pkg::adcf_seq_t seq_q;
   logic [adcf_pkg::CNT_W-1:0] cnt_q;     // cycles left in conversion
   logic [1:0] curCh_q;                   // channel being converted
   logic sleep_q;                         // core asleep
   logic startWr;                         // start command
   logic endEv;                           // conversion ends now
   logic stored;                          // its result is kept
   logic nxtFound;                        // another enabled channel follows
   logic [1:0] nxtCh;                     // which one
   logic firstFound;                      // any channel enabled
   logic [1:0] firstCh;                   // lowest enabled

   // flag events
   logic [N-1:0] doneQ, ovrQ;             // flag states
   logic [N-1:0] doneSet, doneClr;
   logic [N-1:0] ovrSet;
   logic [N-1:0] resRdMask;               // channel result reads
   logic [N-1:0] lastRdMask;              // done flag behind the last result
   logic drdyQ, govrQ;
   logic drdySet, govrSet;
   logic lastRd, statRd;

   // find the lowest enabled channel above a given one
   function automatic logic [2:0] pickNext(input logic [N-1:0] en, input int from);
      logic [2:0] r;
      r = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (i > from && en[i]) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction : pickNext

   // ---------------- bus slave ----------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign rdEn = hsel & htrans[1] & hready & ~hwrite;
   assign rdAddr = haddr[7:0];
   assign wrEn = aph_q.vld & aph_q.wr;

   // capture address phase of each transfer
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         aph_q <= '0;
      end else if (hready) begin
         aph_q.vld <= hsel & htrans[1] & (hsize == 3'h2);
         aph_q.wr <= hwrite;
         aph_q.addr <= {haddr[7:2], 2'h0};
      end
   end

   // read value, chosen in the address phase
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (rdAddr)
         adcf_pkg::OFS_MODE: rdMux[adcf_pkg::MODE_SLEEP] = sleepSel_q;
         adcf_pkg::OFS_CHSTAT: rdMux[N-1:0] = chanEn_q;
         adcf_pkg::OFS_STATUS: begin
            rdMux[adcf_pkg::ST_DONE +: N] = doneQ;
            rdMux[adcf_pkg::ST_OVR +: N] = ovrQ;
            rdMux[adcf_pkg::ST_DATA_READY_FLAG] = drdyQ;
            rdMux[adcf_pkg::ST_GOVR] = govrQ;
            rdMux[adcf_pkg::ST_BUSY] = seq_q == adcf_pkg::SEQ_CONV;
            rdMux[adcf_pkg::ST_SLEEP] = sleep_q;
         end
         adcf_pkg::OFS_LAST: begin
            rdMux[9:0] = lastRes_q;
            rdMux[adcf_pkg::LAST_CH +: 2] = lastCh_q;
         end
         adcf_pkg::OFS_EVENT: rdMux[adcf_pkg::EV_W-1:0] = evt_q;
         adcf_pkg::OFS_MASK: rdMux[adcf_pkg::EV_W-1:0] = mask_q;
         default: begin
            for (int i = 0; i < N; i++) begin
               if (rdAddr == adcf_pkg::OFS_RES0 + 8'(4 * i)) begin
                  rdMux[9:0] = chanRes_q[i];
               end
            end
         end
      endcase
   end

   // read data register, unmapped words read zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rdEn) begin
         hrdata_q <= rdMux;
      end
   end

   // read strobes that clear flags
   always_comb begin
      resRdMask = '0;
      for (int i = 0; i < N; i++) begin
         resRdMask[i] = rdEn && rdAddr == adcf_pkg::OFS_RES0 + 8'(4 * i);
      end
      lastRd = rdEn && rdAddr == adcf_pkg::OFS_LAST;
      statRd = rdEn && rdAddr == adcf_pkg::OFS_STATUS;
      lastRdMask = '0;
      lastRdMask[lastCh_q] = lastRd;
   end

   // ---------------- configuration ----------------
   assign startWr = wrEn && aph_q.addr == adcf_pkg::OFS_CTRL && hwdata[adcf_pkg::CTRL_START];

   // mode, channel enables and mask
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sleepSel_q <= 1'b0;
         chanEn_q <= adcf_pkg::CHEN_RST;
         mask_q <= adcf_pkg::MASK_RST;
      end else if (wrEn) begin
         unique case (aph_q.addr)
            adcf_pkg::OFS_MODE: sleepSel_q <= hwdata[adcf_pkg::MODE_SLEEP];
            adcf_pkg::OFS_CHEN: chanEn_q <= chanEn_q | hwdata[N-1:0];
            adcf_pkg::OFS_CHDIS: chanEn_q <= chanEn_q & ~hwdata[N-1:0];
            adcf_pkg::OFS_MASK: mask_q <= hwdata[adcf_pkg::EV_W-1:0];
            default: ;
         endcase
      end
   end

   // ---------------- sequencer ----------------
   assign endEv = seq_q == adcf_pkg::SEQ_CONV && cnt_q == '0;
   assign stored = endEv & chanEn_q[curCh_q];
   assign {nxtFound, nxtCh} = pickNext(chanEn_q, int'(curCh_q));
   assign {firstFound, firstCh} = pickNext(chanEn_q, -1);
   assign anaChannel = curCh_q;
   assign anaSleep = sleep_q;

   // scan enabled channels upward after a start command
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         seq_q <= adcf_pkg::SEQ_IDLE;
         cnt_q <= '0;
         curCh_q <= 2'h0;
      end else if (startWr && firstFound) begin
         seq_q <= adcf_pkg::SEQ_CONV;
         cnt_q <= adcf_pkg::CNT_W'(adcf_pkg::CONV_CYC - 1);
         curCh_q <= firstCh;
      end else if (endEv) begin
         cnt_q <= adcf_pkg::CNT_W'(adcf_pkg::CONV_CYC - 1);
         curCh_q <= nxtFound ? nxtCh : curCh_q;
         seq_q <= nxtFound ? adcf_pkg::SEQ_CONV : adcf_pkg::SEQ_IDLE;
      end else if (seq_q == adcf_pkg::SEQ_CONV) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // sleep is entered only when a conversion ends
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sleep_q <= 1'b0;
      end else if (startWr) begin
         sleep_q <= 1'b0;
      end else if (endEv && !nxtFound && sleepSel_q) begin
         sleep_q <= 1'b1;
      end
   end

   // ---------------- results ----------------
   // stored data goes to its channel word and to the last word
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lastRes_q <= '0;
         lastCh_q <= 2'h0;
         for (int i = 0; i < N; i++) begin
            chanRes_q[i] <= '0;
         end
      end else if (stored) begin
         chanRes_q[curCh_q] <= anaResult;
         lastRes_q <= anaResult;
         lastCh_q <= curCh_q;
      end
   end

   // ---------------- flags ----------------
   always_comb begin
      doneSet = '0;
      doneSet[curCh_q] = stored;
      doneClr = resRdMask | lastRdMask;
      ovrSet = doneSet & doneQ;
      drdySet = stored;
      govrSet = stored & drdyQ;
   end

   // per-channel done and overrun flags
   for (genvar g = 0; g < N; g++) begin : g_chan
      adcf_flag u_done (
         .clk(ref_clk),
         .rst(srst),
         .setEv(doneSet[g]),
         .clrEv(doneClr[g]),
         .flag(doneQ[g])
      );
      adcf_flag u_ovr (
         .clk(ref_clk),
         .rst(srst),
         .setEv(ovrSet[g]),
         .clrEv(statRd),
         .flag(ovrQ[g])
      );
   end

   // data ready, cleared by the last-result read only
   adcf_flag u_data_ready_flag (
      .clk(ref_clk),
      .rst(srst),
      .setEv(drdySet),
      .clrEv(lastRd),
      .flag(drdyQ)
   );

   // global overrun, cleared by a status read
   adcf_flag u_govr (
      .clk(ref_clk),
      .rst(srst),
      .setEv(govrSet),
      .clrEv(statRd),
      .flag(govrQ)
   );

   // ---------------- interrupts ----------------
   always_comb begin
      evtSet = '0;
      evtSet[adcf_pkg::EV_STORE] = drdySet;
      evtSet[adcf_pkg::EV_GOVR] = govrSet;
      evtSet[adcf_pkg::EV_OVR] = |ovrSet;
      evtSet[adcf_pkg::EV_SLEEP] = endEv && !nxtFound && sleepSel_q && !startWr;
   end

   // sticky events, write one to clear, new event wins
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         evt_q <= '0;
      end else if (wrEn && aph_q.addr == adcf_pkg::OFS_EVENT) begin
         evt_q <= evtSet | (evt_q & ~hwdata[adcf_pkg::EV_W-1:0]);
      end else begin
         evt_q <= evtSet | evt_q;
      end
   end

   assign irq = |(evt_q & mask_q);

   // ---------------- checks ----------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_store_busy;
      stored && drdyQ;
   endsequence

   // raised the cycle after the store, then held unless a status read took it
   sequence s_ovr_seen;
      ##1 govrQ ##1 (govrQ || $past(statRd));
   endsequence

   a_data_ready_flag_cdr_keep: assert property (
      (drdyQ && !lastRd) |=> drdyQ)
      else $error("data ready lost without last-result read");

   a_store_raise: assert property (
      stored |=> drdyQ && lastRes_q == $past(anaResult))
      else $error("stored result not reflected");

   a_done_clear: assert property (
      (doneClr != '0 && doneSet == '0) |=> (doneQ & $past(doneClr)) == '0)
      else $error("done flag not cleared by read");

   a_govr_raise: assert property (
      s_store_busy |-> s_ovr_seen)
      else $error("global overrun not raised");

   a_govr_clear: assert property (
      (statRd && !govrSet) |=> !govrQ)
      else $error("global overrun not cleared by status read");

   a_ovr_raise: assert property (
      ovrSet != '0 |=> (ovrQ & $past(ovrSet)) == $past(ovrSet))
      else $error("channel overrun missed");

   a_ovr_clear: assert property (
      (statRd && ovrSet == '0) |=> ovrQ == '0)
      else $error("channel overruns not cleared");

   a_done_disabled: assert property (
      (endEv && !stored) |=> (doneQ & ~$past(doneQ)) == '0)
      else $error("done flag rose on disabled channel");

   a_done_only_own: assert property (
      (resRdMask != '0 && !lastRd) |=>
         (doneQ & ~$past(resRdMask)) == ($past(doneQ | doneSet) & ~$past(resRdMask)))
      else $error("foreign done flag disturbed");

   a_data_ready_flag_unstored: assert property (
      (endEv && !stored && !drdyQ) |=> !drdyQ)
      else $error("data ready set without stored data");

   a_sleep_at_end: assert property (
      $rose(sleep_q) |-> $past(endEv) && $past(sleepSel_q))
      else $error("sleep entered outside a conversion end");

   a_set_wins: assert property (
      (drdySet && lastRd) |=> drdyQ ##1 (drdyQ || $past(lastRd)))
      else $error("clear beat a data-ready set");
endmodule : adcf_status

// >>> bench/adcf_status_tb_top.sv
// self-checking register-level bench for the converter status-flag block
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD %0t got %h expected %h", $time, got, exp); end end

module adcf_status_tb_top;
   localparam logic [7:0] A_CTRL = adcf_pkg::OFS_CTRL; // start command
   localparam logic [7:0] A_MODE = adcf_pkg::OFS_MODE; // sleep selection
   localparam logic [7:0] A_EN = adcf_pkg::OFS_CHEN; // channel enable
   localparam logic [7:0] A_DIS = adcf_pkg::OFS_CHDIS; // channel disable
   localparam logic [7:0] A_ENST = adcf_pkg::OFS_CHSTAT; // enabled channels
   localparam logic [7:0] A_ST = adcf_pkg::OFS_STATUS; // status flags
   localparam logic [7:0] A_LAST = adcf_pkg::OFS_LAST; // last_result_register
   localparam logic [7:0] A_EV = adcf_pkg::OFS_EVENT; // sticky events
   localparam logic [7:0] A_MASK = adcf_pkg::OFS_MASK; // interrupt mask
   localparam logic [7:0] A_RES0 = adcf_pkg::OFS_RES0; // channel 0 result
   localparam logic [31:0] BUSY = 32'h0000_0001 << adcf_pkg::ST_BUSY; // busy bit
   logic ref_clk = 1'b0; // bench clock
   logic srst = 1'b1; // reset, high
   logic hsel = 1'b0; // slave select
   logic [31:0] haddr = 32'h0000_0000; // byte address
   logic [1:0] htrans = 2'h0; // idle
   logic hwrite = 1'b0; // direction
   logic [2:0] hsize = 3'h2; // word
   logic [31:0] hwdata = 32'h0000_0000; // write data
   logic [31:0] hrdata; // read data
   logic hreadyout; // slave ready, fed back as hready
   logic hresp; // response
   logic [9:0] anaResult = 10'h000; // analog word
   logic [1:0] anaChannel; // channel under conversion
   logic anaSleep; // core asleep
   logic irq; // interrupt
   int miscompares = 0; // mismatches
   int checked = 0; // comparisons made
   logic [31:0] q; // scratch read value

   // clock at 40 MHz
   always #12.5 ref_clk = ~ref_clk;

   // analog core answers with a word that names its channel
   always @(posedge ref_clk) begin
      anaResult <= 10'h100 | {8'h00, anaChannel};
   end

   adcf_status dut_u (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .anaResult(anaResult),
      .anaChannel(anaChannel), .anaSleep(anaSleep), .irq(irq));

   // verdict and end of run
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // one edge with hready high, bounded
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         $display("BAD %0t bus wait expired", $time);
         miscompares++;
         tally_and_finish();
      end
   endtask : wait_ready

   // single word transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
      `CHK(hresp, 1'b0)
   endtask : bus

   // write one register
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   // read one register and compare
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      `CHK(q, e)
   endtask : rd

   // status word from its fields
   function automatic logic [31:0] stv(input logic [3:0] dn, input logic [3:0] ov,
         input logic dr, input logic go, input logic sl);
      stv = (32'(dn) << adcf_pkg::ST_DONE) | (32'(ov) << adcf_pkg::ST_OVR) |
         (32'(dr) << adcf_pkg::ST_DATA_READY_FLAG) | (32'(go) << adcf_pkg::ST_GOVR) |
         (32'(sl) << adcf_pkg::ST_SLEEP);
   endfunction : stv

   // wait out a scan of n channels
   task automatic wait_scan(input int n);
      repeat (n * adcf_pkg::CONV_CYC + 8) @(posedge ref_clk);
   endtask : wait_scan

   // start a scan and put a read address phase on the edge that ends the conversion
   task automatic conv_hit(input logic [7:0] a, input logic [31:0] e);
      wr(A_CTRL, 32'h0000_0001);
      repeat (adcf_pkg::CONV_CYC - 1) @(posedge ref_clk);
      rd(a, e);
   endtask : conv_hit

   // hang guard
   initial begin
      #(25.0 * 60000);
      $display("BAD %0t run limit expired", $time);
      miscompares++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      // reset values and an unmapped place
      rd(A_ST, stv(4'h0, 4'h0, 1'b0, 1'b0, 1'b0));
      rd(A_ENST, 32'h0000_0000);
      rd(A_MASK, 32'(adcf_pkg::MASK_RST));
      rd(8'h08, 32'h0000_0000);
      `CHK(irq, 1'b0)
      // two-channel scan: store, data ready, general overrun
      wr(A_EN, 32'h0000_0003);
      rd(A_ENST, 32'h0000_0003);
      wr(A_CTRL, 32'h0000_0001);
      rd(A_ST, BUSY);
      wait_scan(2);
      rd(A_ST, stv(4'h3, 4'h0, 1'b1, 1'b1, 1'b0));
      rd(A_RES0, 32'h0000_0100);
      rd(A_ST, stv(4'h2, 4'h0, 1'b1, 1'b0, 1'b0));
      rd(A_LAST, 32'h0000_1101);
      rd(A_ST, stv(4'h0, 4'h0, 1'b0, 1'b0, 1'b0));
      rd(A_RES0 + 8'h04, 32'h0000_0101);
      rd(A_EV, 32'h0000_0003);
      wr(A_EV, 32'h0000_000F);
      rd(A_EV, 32'h0000_0000);
      // two scans unread: channel overruns
      wr(A_CTRL, 32'h0000_0001);
      wait_scan(2);
      wr(A_CTRL, 32'h0000_0001);
      wait_scan(2);
      rd(A_ST, stv(4'h3, 4'h3, 1'b1, 1'b1, 1'b0));
      rd(A_ST, stv(4'h3, 4'h0, 1'b1, 1'b0, 1'b0));
      rd(A_EV, 32'h0000_0007);
      `CHK(irq, 1'b0)
      // interrupt masked in, then cleared
      wr(A_MASK, 32'h0000_0004);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      wr(A_EV, 32'h0000_0004);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      rd(A_LAST, 32'h0000_1101);
      rd(A_RES0, 32'h0000_0100);
      rd(A_ST, stv(4'h0, 4'h0, 1'b0, 1'b0, 1'b0));
      // channel disabled during its conversion: nothing stored
      wr(A_DIS, 32'h0000_0003);
      wr(A_EN, 32'h0000_0004);
      rd(A_ENST, 32'h0000_0004);
      wr(A_CTRL, 32'h0000_0001);
      repeat (10) @(posedge ref_clk);
      `CHK(anaChannel, 2'h2)
      wr(A_DIS, 32'h0000_0004);
      rd(A_ENST, 32'h0000_0000);
      wait_scan(1);
      rd(A_ST, stv(4'h0, 4'h0, 1'b0, 1'b0, 1'b0));
      rd(A_LAST, 32'h0000_1101);
      // sleep chosen while idle waits for a conversion end
      wr(A_MODE, 32'h0000_0001);
      rd(A_MODE, 32'h0000_0001);
      repeat (20) @(posedge ref_clk);
      `CHK(anaSleep, 1'b0)
      wr(A_EN, 32'h0000_0001);
      wr(A_CTRL, 32'h0000_0001);
      wait_scan(1);
      `CHK(anaSleep, 1'b1)
      rd(A_ST, stv(4'h1, 4'h0, 1'b1, 1'b0, 1'b1));
      bus(1'b0, A_EV, 32'h0000_0000);
      `CHK(q[adcf_pkg::EV_SLEEP], 1'b1)
      // reads that fall on the very edge at which a conversion ends
      rd(A_LAST, 32'h0000_0100);
      conv_hit(A_LAST, 32'h0000_0100);
      rd(A_ST, stv(4'h1, 4'h0, 1'b1, 1'b0, 1'b1));
      conv_hit(A_ST, stv(4'h1, 4'h0, 1'b1, 1'b0, 1'b0) | BUSY);
      rd(A_RES0, 32'h0000_0100);
      conv_hit(A_ST, stv(4'h0, 4'h1, 1'b1, 1'b1, 1'b0) | BUSY);
      rd(A_ST, stv(4'h1, 4'h0, 1'b1, 1'b1, 1'b1));
      // channel dropped mid-conversion, last-result read on its end edge
      wr(A_CTRL, 32'h0000_0001);
      repeat (10) @(posedge ref_clk);
      wr(A_DIS, 32'h0000_0001);
      repeat (adcf_pkg::CONV_CYC - 13) @(posedge ref_clk);
      rd(A_LAST, 32'h0000_0100);
      rd(A_ST, stv(4'h0, 4'h0, 1'b0, 1'b0, 1'b1));
      tally_and_finish();
   end
endmodule : adcf_status_tb_top
